// *** isj_pkg.sv ***
// Constants and carrier types for the five-instruction execution block.
// Assumes the surrounding core supplies decoded operands and file data each cycle.
//
// Overview of operation
// - Decrement-skip writes f minus one, flags kept.
// - Zero decrement result turns next instruction into NOP.
// - Increment-skip writes f plus one, flags kept.
// - Zero increment result turns next instruction into NOP.
// - Jump loads literal and page latch bits.
// - Jump takes two cycles, flags kept.
// - OR literal into accumulator, zero flag updated.
// - Increment file register, zero flag updated.
package isj_pkg;

   // ==========================================================
   // Widths and field positions
   localparam int DATA_W      = 8;
   localparam int FADDR_W     = 7;
   localparam int LIT_W       = 11;
   localparam int PC_W        = 13;
   localparam int PAGE_LO     = 3;
   localparam int PAGE_HI     = 4;
   localparam logic DEST_ACC  = 1'b0;
   localparam logic DEST_FILE = 1'b1;

   // ==========================================================
   // Operation codes presented by the decoder
   typedef enum logic [2:0] {
      ISJ_OP_NONE,
      ISJ_OP_DEC_SKIP,
      ISJ_OP_INC_SKIP,
      ISJ_OP_INC,
      ISJ_OP_OR_LIT,
      ISJ_OP_JUMP
   } isj_op_e;

   typedef enum logic [1:0] {
      ISJ_ST_RUN,
      ISJ_ST_FLUSH
   } isj_state_e;

   typedef struct packed {
      logic                valid;
      isj_op_e             op;
      logic                dest;
      logic [FADDR_W-1:0]  faddr;
      logic [LIT_W-1:0]    literal;
      logic [DATA_W-1:0]   file_data;
      logic [DATA_W-1:0]   acc;
      logic [DATA_W-1:0]   page_latch;
   } isj_req_s;

   typedef struct packed {
      logic                acc_we;
      logic [DATA_W-1:0]   acc_data;
      logic                file_we;
      logic [FADDR_W-1:0]  file_addr;
      logic [DATA_W-1:0]   file_data;
      logic                zero_we;
      logic                zero_val;
      logic                pc_load;
      logic [PC_W-1:0]     pc_value;
   } isj_res_s;

   typedef struct packed {
      isj_state_e  st;
      isj_res_s    res;
   } isj_state_s;

endpackage : isj_pkg

// *** isj_exec.sv ***
// Execution logic for decrement/increment-skip, increment, OR-literal and jump.
// Assumes one req_i per instruction cycle (enable pulse cyc_en_i) from the decoder.
`timescale 1ns/1ns
`default_nettype none
module isj_exec (
   input  wire logic              ref_clk_i,
   input  wire logic              rst_i,
   input  wire logic              cyc_en_i,
   input  wire isj_pkg::isj_req_s req_i,
   output logic                   busy_o,
   output isj_pkg::isj_res_s      res_o
);
   import isj_pkg::*;

   isj_state_s s_q;
   isj_state_s s_d;
   logic [DATA_W-1:0] inc_v;
   logic [DATA_W-1:0] dec_v;
   logic [DATA_W-1:0] res_v;

   // ==========================================================
   // Next-state logic
   always_comb begin
      inc_v = req_i.file_data + 8'h01;
      dec_v = req_i.file_data - 8'h01;
      res_v = 8'h00;
      s_d = s_q;
      if (cyc_en_i) begin
         s_d.res = '0;
         s_d.st  = ISJ_ST_RUN;
         // Instruction in the flushed slot is discarded, acting as a NOP
         if (s_q.st == ISJ_ST_RUN && req_i.valid) begin
            case (req_i.op)
               ISJ_OP_DEC_SKIP, ISJ_OP_INC_SKIP, ISJ_OP_INC: begin
                  res_v = (req_i.op == ISJ_OP_DEC_SKIP) ? dec_v : inc_v;
                  s_d.res.acc_we    = (req_i.dest == DEST_ACC);
                  s_d.res.file_we   = (req_i.dest == DEST_FILE);
                  s_d.res.acc_data  = res_v;
                  s_d.res.file_data = res_v;
                  s_d.res.file_addr = req_i.faddr;
                  if (req_i.op == ISJ_OP_INC) begin
                     s_d.res.zero_we  = 1'b1;
                     s_d.res.zero_val = (res_v == 8'h00);
                  end else if (res_v == 8'h00) begin
                     s_d.st = ISJ_ST_FLUSH;
                  end
               end
               ISJ_OP_OR_LIT: begin
                  res_v = req_i.acc | req_i.literal[DATA_W-1:0];
                  s_d.res.acc_we   = 1'b1;
                  s_d.res.acc_data = res_v;
                  s_d.res.zero_we  = 1'b1;
                  s_d.res.zero_val = (res_v == 8'h00);
               end
               ISJ_OP_JUMP: begin
                  s_d.res.pc_load  = 1'b1;
                  s_d.res.pc_value = {req_i.page_latch[PAGE_HI:PAGE_LO], req_i.literal};
                  s_d.st = ISJ_ST_FLUSH;
               end
               default: begin
                  s_d.st = ISJ_ST_RUN;
               end
            endcase
         end
      end
   end

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign busy_o = (s_q.st == ISJ_ST_FLUSH);
   assign res_o  = s_q.res;

   // ==========================================================
   // Checks
   a_skip_flushes: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      cyc_en_i && !busy_o && req_i.valid && req_i.op == ISJ_OP_DEC_SKIP
      && req_i.file_data == 8'h01 |=> busy_o)
      else $error("decrement to zero did not skip");
   a_inc_skip_flush: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      cyc_en_i && !busy_o && req_i.valid && req_i.op == ISJ_OP_INC_SKIP
      && req_i.file_data == 8'hFF |=> busy_o)
      else $error("increment wrap did not skip");
   a_no_flag_skip: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      cyc_en_i && !busy_o && req_i.valid && req_i.op == ISJ_OP_DEC_SKIP
      |=> !res_o.zero_we && res_o.acc_data == $past(req_i.file_data) - 8'h01)
      else $error("decrement-skip result or flag wrong");
   a_inc_dest_sel: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      cyc_en_i && !busy_o && req_i.valid && req_i.op == ISJ_OP_INC_SKIP
      |=> res_o.file_we == $past(req_i.dest) && !res_o.zero_we)
      else $error("increment-skip destination wrong");
   a_jump_target: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      cyc_en_i && !busy_o && req_i.valid && req_i.op == ISJ_OP_JUMP
      |=> res_o.pc_load && res_o.pc_value[LIT_W-1:0] == $past(req_i.literal)
      && res_o.pc_value[PC_W-1:LIT_W] == $past(req_i.page_latch[PAGE_HI:PAGE_LO]))
      else $error("jump target wrong");
   a_jump_two_cyc: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      cyc_en_i && !busy_o && req_i.valid && req_i.op == ISJ_OP_JUMP
      |=> busy_o && !res_o.zero_we)
      else $error("jump not two cycles");
   a_or_result: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      cyc_en_i && !busy_o && req_i.valid && req_i.op == ISJ_OP_OR_LIT
      |=> res_o.acc_we && res_o.zero_we
      && res_o.acc_data == ($past(req_i.acc) | $past(req_i.literal[DATA_W-1:0])))
      else $error("OR literal result wrong");
   a_inc_zero: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      cyc_en_i && !busy_o && req_i.valid && req_i.op == ISJ_OP_INC
      |=> res_o.zero_we && !busy_o)
      else $error("increment flag or timing wrong");
   a_zero_exact: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      res_o.zero_we |-> res_o.zero_val == (res_o.acc_we ? res_o.acc_data == 8'h00
      : res_o.file_data == 8'h00))
      else $error("zero flag mismatch");
   a_single_cycle: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      cyc_en_i && !busy_o && req_i.valid && req_i.op == ISJ_OP_DEC_SKIP
      && req_i.file_data != 8'h01 |=> !busy_o)
      else $error("nonzero skip took two cycles");

endmodule : isj_exec
`default_nettype wire

// *** incdec_skip_jump_or_exec_bench.sv ***
// Self-checking bench for isj_exec: random instruction stream with forced corners.
// Assumes isj_pkg is compiled first; inputs are driven on the falling clock edge.
`timescale 1ns/1ns
`default_nettype none
module incdec_skip_jump_or_exec_bench;
   import isj_pkg::*;
   logic        ref_clk_i, rst_i, cyc_en_i, busy_o, exp_busy, sk, aw, fw, zw;
   isj_req_s    req_i;
   isj_res_s    res_o;
   int          mismatches, tests_run;
   logic [31:0] seed;
   logic [7:0]  r;

   isj_exec uut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .cyc_en_i(cyc_en_i),
                 .req_i(req_i), .busy_o(busy_o), .res_o(res_o));

   initial begin
      ref_clk_i = 1'b0;
      forever #5 ref_clk_i = ~ref_clk_i;
   end
   // ==========================================================
   // Helpers
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction : lfsr
   function automatic logic [7:0] result(input isj_req_s q);
      if (q.op == ISJ_OP_DEC_SKIP) return q.file_data - 8'h01;
      if (q.op == ISJ_OP_OR_LIT) return q.acc | q.literal[7:0];
      return q.file_data + 8'h01;
   endfunction : result
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR at %0t ns: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic report_and_stop;
      $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : report_and_stop
   initial begin
      #20000;
      mismatches++;
      report_and_stop();
   end
   // ==========================================================
   // Main sequence
   initial begin
      rst_i = 1'b1; cyc_en_i = 1'b0; req_i = '0; seed = 32'h554433B8; exp_busy = 1'b0;
      repeat (2) @(negedge ref_clk_i);
      rst_i = 1'b0;
      chk({15'h0000, busy_o}, 16'h0000);
      chk(16'(res_o != '0), 16'h0000);
      for (int i = 0; i < 300; i++) begin
         seed = lfsr(seed);
         req_i.valid = 1'b1;
         req_i.op = isj_op_e'(3'(seed[7:0] % 8'd5 + 8'd1));
         {req_i.dest, req_i.faddr, req_i.literal} = seed[26:8];
         req_i.acc = seed[31:24];
         seed = lfsr(seed);
         {req_i.file_data, req_i.page_latch} = seed[15:0];
         // Wrap and zero corners are rare in random data, so force them often
         if (seed[17:16] == 2'b00) req_i.file_data = 8'h01;
         if (seed[17:16] == 2'b01) req_i.file_data = 8'hFF;
         if (seed[20:18] == 3'b000) {req_i.acc, req_i.literal} = '0;
         cyc_en_i = 1'b1;
         @(negedge ref_clk_i);
         cyc_en_i = 1'b0;
         if (exp_busy) begin
            chk({15'h0000, busy_o}, 16'h0000);
            chk(16'(res_o != '0), 16'h0000);
            exp_busy = 1'b0;
         end else begin
            r  = result(req_i);
            sk = (req_i.op == ISJ_OP_DEC_SKIP) || (req_i.op == ISJ_OP_INC_SKIP);
            aw = (req_i.op == ISJ_OP_OR_LIT) ||
                 (req_i.op != ISJ_OP_JUMP && req_i.dest == DEST_ACC);
            fw = req_i.op != ISJ_OP_JUMP && req_i.op != ISJ_OP_OR_LIT && req_i.dest == DEST_FILE;
            zw = (req_i.op == ISJ_OP_INC) || (req_i.op == ISJ_OP_OR_LIT);
            exp_busy = (sk && r == 8'h00) || req_i.op == ISJ_OP_JUMP;
            chk({15'h0000, busy_o}, {15'h0000, exp_busy});
            chk({res_o.acc_we, res_o.file_we}, {aw, fw});
            chk({15'h0000, res_o.zero_we}, {15'h0000, zw});
            chk({15'h0000, res_o.pc_load}, 16'(req_i.op == ISJ_OP_JUMP));
            if (aw) chk({8'h00, res_o.acc_data}, {8'h00, r});
            if (fw) chk({1'b0, res_o.file_addr, res_o.file_data}, {1'b0, req_i.faddr, r});
            if (zw) chk({15'h0000, res_o.zero_val}, 16'(r == 8'h00));
            if (req_i.op == ISJ_OP_JUMP)
               chk({3'b000, res_o.pc_value}, {3'b000, req_i.page_latch[4:3], req_i.literal});
         end
         if (seed[30]) @(negedge ref_clk_i);
      end
      report_and_stop();
   end
endmodule : incdec_skip_jump_or_exec_bench
`default_nettype wire
